// [pkg/bsfc_pkg.sv]
// Constants for the buck switching sync and fault control block
// What this block does
// - Lock switching cycles to an external clock between 200 kHz and 1600 kHz.
// - In external-clock mode each cycle starts on the pin's falling edge.
// - Without a detected external clock, use resistor-set frequency mode.
// - First rise above high threshold enters clock mode and releases the pin.
// - After 10 us without a falling clock edge, return to resistor-set mode.
// - Stretch toward full duty when off-time would be under 200 ns.
// - Gate-drive capacitor undervoltage forces high side off, low side on.
// - Recharge gate-drive capacitor only while the low side conducts.
// - Feedback above overvoltage threshold forces high side off, low side on.
// - High side may restart next cycle once feedback drops below release.
// - End high-side on-time when switch current meets the reference.
// - Peak high-side current bounded by a clamped internal reference.
// - Clamp held over 512 cycles shuts down; restart after 16384 cycles.
// - Low-side source limit at cycle end skips next high pulse, low stays on.
// - Resume high pulses at first cycle start with source current below limit.
// - Sink limit turns low side off at once; both off until next cycle.
// - After sink turn-off, low side only after a high pulse or undervoltage.
// - Active only with both supply lockout and enable thresholds exceeded.
// - Floating enable reads asserted; enable low gives low-quiescent shutdown.
// - Discharge soft-start node before every new power-up sequence.
package bsfc_pkg;
    localparam int SYS_CLK_HZ = 20_000_000;
    localparam int SYS_PER_NS = 50;
    localparam int SYNC_MIN_KHZ = 200;
    localparam int SYNC_MAX_KHZ = 1600;
    localparam int PER_MAX_CYC = SYS_CLK_HZ / (SYNC_MIN_KHZ * 1000);
    localparam int PER_MIN_CYC = SYS_CLK_HZ / (SYNC_MAX_KHZ * 1000);
    localparam int CLK_LOSS_NS = 10_000;
    localparam int CLK_LOSS_CYC = (CLK_LOSS_NS + SYS_PER_NS - 1) / SYS_PER_NS;
    localparam int MIN_OFF_NS = 200;
    localparam int MIN_OFF_CYC = (MIN_OFF_NS + SYS_PER_NS - 1) / SYS_PER_NS;
    localparam int RT_PER_CYC = 40;
    localparam int HIC_WAIT_CYC = 512;
    localparam int HIC_RESTART_CYC = 16384;
    localparam int SS_DIS_CYC = 32;
    localparam int CNT_W = 8;
    localparam int WAIT_W = 10;
    localparam int HIC_W = 15;
    localparam int SS_W = 6;
    localparam logic [CNT_W-1:0] CNT_MAX = 8'hFF;

    typedef enum logic [1:0] {
        BSFC_OFF = 2'b00,
        BSFC_DISCH = 2'b01,
        BSFC_RUN = 2'b11,
        BSFC_HICCUP = 2'b10
    } bsfc_state_e;
endpackage

// [pkg/bsfc_cyc_if.sv]
// Switching cycle timing passed from clock select to control
`timescale 1ns/1ps
interface bsfc_cyc_if;
    logic cyc_start;
    logic ext_mode;
    logic locked;
    logic [bsfc_pkg::CNT_W-1:0] per;
    modport src (output cyc_start, ext_mode, locked, per);
    modport snk (input cyc_start, ext_mode, locked, per);
endinterface

// [src/bsfc_cyc_cnt.sv]
// Saturating cycle counter with limit flag
`timescale 1ns/1ps
module bsfc_cyc_cnt #(
    parameter int W = 10,
    parameter int LIMIT = 512
) (
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire logic clr,
    input wire logic inc,
    output logic done_q
);
    logic [W-1:0] cnt_q;
    logic [W-1:0] cnt_d;
    logic done_d;

    always_comb
    begin
        cnt_d = cnt_q;
        if (clr)
        begin
            cnt_d = '0;
        end
        else if (inc && (cnt_q != W'(LIMIT)))
        begin
            cnt_d = cnt_q + W'(1);
        end
        done_d = !clr && (cnt_d == W'(LIMIT));
    end

    always_ff @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            cnt_q <= '0;
            done_q <= 1'b0;
        end
        else
        begin
            cnt_q <= cnt_d;
            done_q <= done_d;
        end
    end
endmodule // bsfc_cyc_cnt

// [src/bsfc_clk_sel.sv]
// Resistor-set and external clock selection with loss timeout
`timescale 1ns/1ps
module bsfc_clk_sel (
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire logic pin_i,
    bsfc_cyc_if.src cyc
);
    logic pin_q, pin_d, prev_q, ext_q, ext_d, lock_q, lock_d, start_q, start_d;
    logic rise, fall;
    logic [bsfc_pkg::CNT_W-1:0] cnt_q, cnt_d, per_q, per_d;

    always_comb
    begin
        pin_d = pin_i;
        rise = !prev_q && pin_q;
        fall = prev_q && !pin_q;
        ext_d = ext_q;
        lock_d = lock_q;
        per_d = per_q;
        start_d = 1'b0;
        cnt_d = (cnt_q == bsfc_pkg::CNT_MAX) ? cnt_q : cnt_q + 8'h01;
        if (!ext_q)
        begin
            if (rise)
            begin
                ext_d = 1'b1;
                lock_d = 1'b0;
                cnt_d = '0;
            end
            else if (cnt_q >= 8'(bsfc_pkg::RT_PER_CYC - 1))
            begin
                start_d = 1'b1;
                cnt_d = '0;
            end
        end
        else if (fall)
        begin
            start_d = 1'b1;
            cnt_d = '0;
            per_d = cnt_q + 8'h_01;
            lock_d = (per_d >= 8'(bsfc_pkg::PER_MIN_CYC))
                && (per_d <= 8'(bsfc_pkg::PER_MAX_CYC));
        end
        else if (cnt_q >= 8'(bsfc_pkg::CLK_LOSS_CYC - 1))
        begin
            ext_d = 1'b0;
            lock_d = 1'b0;
            cnt_d = '0;
            per_d = 8'(bsfc_pkg::RT_PER_CYC);
        end
    end

    always_ff @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            pin_q <= 1'b1;
            prev_q <= 1'b1;
            ext_q <= 1'b0;
            lock_q <= 1'b0;
            start_q <= 1'b0;
            cnt_q <= '0;
            per_q <= 8'(bsfc_pkg::RT_PER_CYC);
        end
        else
        begin
            pin_q <= pin_d;
            prev_q <= pin_q;
            ext_q <= ext_d;
            lock_q <= lock_d;
            start_q <= start_d;
            cnt_q <= cnt_d;
            per_q <= per_d;
        end
    end

    assign cyc.cyc_start = start_q;
    assign cyc.ext_mode = ext_q;
    assign cyc.locked = lock_q;
    assign cyc.per = per_q;
endmodule // bsfc_clk_sel

// [src/bsfc_top.sv]
// Switching cycle, protection and enable control for the step-down stage
`timescale 1ns/1ps
module bsfc_top #(
    parameter int HIC_RESTART_CYC = bsfc_pkg::HIC_RESTART_CYC
) (
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire logic freq_set_pin_i,
    output logic freq_set_pin_o,
    output logic freq_set_pin_oe_b,
    input wire logic en_hi,
    input wire logic vin_ok,
    input wire logic boot_uv,
    input wire logic fb_above_ovp,
    input wire logic fb_below_release,
    input wire logic cur_trip,
    input wire logic cur_peak_clamp,
    input wire logic comp_clamped,
    input wire logic ls_src_lim,
    input wire logic ls_sink_lim,
    output logic hs_on_q,
    output logic ls_on_q,
    output logic boot_charge_q,
    output logic ovp_active_q,
    output logic ss_discharge_q,
    output logic active_q,
    output logic low_iq_q,
    output logic hiccup_q,
    output logic ext_mode_q,
    output logic pll_locked_q
);
    bsfc_cyc_if cyc ();

    bsfc_clk_sel u_clk_sel (
        .sys_clk(sys_clk),
        .rst_b(rst_b),
        .pin_i(freq_set_pin_i),
        .cyc(cyc.src)
    );

    // Registered comparator results
    logic en_q, vin_q, buv_q, ovh_q, ovl_q, pk_q, clamp_q, src_q, sink_q;
    always_ff @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            en_q <= 1'b0;
            vin_q <= 1'b0;
            buv_q <= 1'b0;
            ovh_q <= 1'b0;
            ovl_q <= 1'b0;
            pk_q <= 1'b0;
            clamp_q <= 1'b0;
            src_q <= 1'b0;
            sink_q <= 1'b0;
        end
        else
        begin
            en_q <= en_hi;
            vin_q <= vin_ok;
            buv_q <= boot_uv;
            ovh_q <= fb_above_ovp;
            ovl_q <= fb_below_release;
            pk_q <= cur_trip || cur_peak_clamp;
            clamp_q <= comp_clamped;
            src_q <= ls_src_lim;
            sink_q <= ls_sink_lim;
        end
    end

    // Hiccup wait and restart counts
    logic wait_done, hic_done;
    bsfc_pkg::bsfc_state_e st_q, st_d;

    bsfc_cyc_cnt #(
        .W(bsfc_pkg::WAIT_W),
        .LIMIT(bsfc_pkg::HIC_WAIT_CYC + 1)
    ) u_wait_cnt (
        .sys_clk(sys_clk),
        .rst_b(rst_b),
        .clr(!(st_q == bsfc_pkg::BSFC_RUN && clamp_q)),
        .inc(cyc.cyc_start),
        .done_q(wait_done)
    );

    bsfc_cyc_cnt #(
        .W(bsfc_pkg::HIC_W + 1),
        .LIMIT(HIC_RESTART_CYC)
    ) u_hic_cnt (
        .sys_clk(sys_clk),
        .rst_b(rst_b),
        .clr(st_q != bsfc_pkg::BSFC_HICCUP),
        .inc(cyc.cyc_start),
        .done_q(hic_done)
    );

    // Power state
    logic [bsfc_pkg::SS_W-1:0] ss_cnt_q, ss_cnt_d;
    logic en_ok;
    always_comb
    begin
        en_ok = en_q && vin_q;
        st_d = st_q;
        ss_cnt_d = ss_cnt_q;
        if (!en_ok)
        begin
            st_d = bsfc_pkg::BSFC_OFF;
        end
        else
        begin
            unique case (st_q)
                bsfc_pkg::BSFC_OFF:
                begin
                    st_d = bsfc_pkg::BSFC_DISCH;
                    ss_cnt_d = '0;
                end
                bsfc_pkg::BSFC_DISCH:
                begin
                    ss_cnt_d = ss_cnt_q + 6'h01;
                    if (ss_cnt_q == 6'(bsfc_pkg::SS_DIS_CYC - 1))
                    begin
                        st_d = bsfc_pkg::BSFC_RUN;
                    end
                end
                bsfc_pkg::BSFC_RUN:
                begin
                    if (wait_done)
                    begin
                        st_d = bsfc_pkg::BSFC_HICCUP;
                    end
                end
                bsfc_pkg::BSFC_HICCUP:
                begin
                    if (hic_done)
                    begin
                        st_d = bsfc_pkg::BSFC_DISCH;
                        ss_cnt_d = '0;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            st_q <= bsfc_pkg::BSFC_OFF;
            ss_cnt_q <= '0;
        end
        else
        begin
            st_q <= st_d;
            ss_cnt_q <= ss_cnt_d;
        end
    end

    // Switch control
    logic hs_d, ls_d, ovp_d, blk_q, blk_d, run;
    logic near_end, hs_allow;
    logic [bsfc_pkg::CNT_W-1:0] pos_q, pos_d;
    always_comb
    begin
        run = (st_q == bsfc_pkg::BSFC_RUN);
        pos_d = cyc.cyc_start ? '0 : ((pos_q == bsfc_pkg::CNT_MAX) ? pos_q : pos_q + 8'h01);
        near_end = (9'(pos_q) + 9'(bsfc_pkg::MIN_OFF_CYC)) >= 9'(cyc.per);
        ovp_d = ovp_active_q;
        if (ovh_q)
        begin
            ovp_d = 1'b1;
        end
        else if (ovl_q)
        begin
            ovp_d = 1'b0;
        end
        hs_allow = !ovp_active_q && !ovh_q && !src_q && !buv_q;
        hs_d = hs_on_q;
        ls_d = ls_on_q;
        blk_d = blk_q;
        if (!run)
        begin
            hs_d = 1'b0;
            ls_d = 1'b0;
            blk_d = 1'b0;
        end
        else if (cyc.cyc_start && !(hs_on_q && !buv_q && !ovh_q && hs_allow))
        begin
            hs_d = hs_allow;
            ls_d = !hs_allow && (!blk_q || buv_q);
        end
        else if (cyc.cyc_start)
        begin
            hs_d = 1'b1;
            ls_d = 1'b0;
        end
        else if (hs_on_q && (buv_q || ovh_q || (pk_q && !near_end)))
        begin
            hs_d = 1'b0;
            ls_d = 1'b1;
            blk_d = 1'b0;
        end
        else if (!hs_on_q && buv_q)
        begin
            ls_d = 1'b1;
            blk_d = 1'b0;
        end
        if (run && ls_d && sink_q && !hs_d)
        begin
            ls_d = 1'b0;
            blk_d = 1'b1;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            hs_on_q <= 1'b0;
            ls_on_q <= 1'b0;
            blk_q <= 1'b0;
            pos_q <= '0;
            ovp_active_q <= 1'b0;
            boot_charge_q <= 1'b0;
            ss_discharge_q <= 1'b0;
            active_q <= 1'b0;
            low_iq_q <= 1'b1;
            hiccup_q <= 1'b0;
            ext_mode_q <= 1'b0;
            pll_locked_q <= 1'b0;
            freq_set_pin_o <= 1'b0;
            freq_set_pin_oe_b <= 1'b1;
        end
        else
        begin
            hs_on_q <= hs_d;
            ls_on_q <= ls_d;
            blk_q <= blk_d;
            pos_q <= pos_d;
            ovp_active_q <= ovp_d;
            boot_charge_q <= ls_d && buv_q;
            ss_discharge_q <= (st_d == bsfc_pkg::BSFC_DISCH);
            active_q <= (st_d == bsfc_pkg::BSFC_RUN);
            low_iq_q <= !en_q;
            hiccup_q <= (st_d == bsfc_pkg::BSFC_HICCUP);
            ext_mode_q <= cyc.ext_mode;
            pll_locked_q <= cyc.locked;
            freq_set_pin_o <= 1'b0;
            freq_set_pin_oe_b <= cyc.ext_mode;
        end
    end
endmodule // bsfc_top

// [verification/bsfc_checker.sv]
// Concurrent checks on the top module ports
`timescale 1ns/1ps
module bsfc_checker (
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire logic en_hi,
    input wire logic vin_ok,
    input wire logic boot_uv,
    input wire logic fb_above_ovp,
    input wire logic ls_src_lim,
    input wire logic ls_sink_lim,
    input wire logic freq_set_pin_oe_b,
    input wire logic hs_on_q,
    input wire logic ls_on_q,
    input wire logic boot_charge_q,
    input wire logic ovp_active_q,
    input wire logic ss_discharge_q,
    input wire logic active_q,
    input wire logic low_iq_q,
    input wire logic ext_mode_q
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_b);

    property p_excl; !(hs_on_q && ls_on_q); endproperty
    a_excl: assert property (p_excl) else $error("both gates on");
    property p_boot; (boot_uv && active_q)[*3] |-> !hs_on_q; endproperty
    a_boot: assert property (p_boot) else $error("hs on in boot uv");
    property p_chg; boot_charge_q |-> ls_on_q; endproperty
    a_chg: assert property (p_chg) else $error("charge without ls");
    property p_ovp; (fb_above_ovp && active_q)[*3] |-> !hs_on_q; endproperty
    a_ovp: assert property (p_ovp) else $error("hs on in ovp");
    property p_rel; $rose(hs_on_q) |-> !ovp_active_q; endproperty
    a_rel: assert property (p_rel) else $error("hs start while latched");
    property p_src; ls_src_lim[*3] |-> !$rose(hs_on_q); endproperty
    a_src: assert property (p_src) else $error("hs start over src limit");
    property p_sink;
        (ls_on_q && ls_sink_lim && !boot_uv) ##1 (ls_sink_lim && !boot_uv) |=> !ls_on_q;
    endproperty
    a_sink: assert property (p_sink) else $error("ls on over sink limit");
    property p_pwr; (!(en_hi && vin_ok))[*4] |-> !active_q && !hs_on_q && !ls_on_q; endproperty
    a_pwr: assert property (p_pwr) else $error("active while off");
    property p_liq; (!en_hi)[*4] |-> low_iq_q; endproperty
    a_liq: assert property (p_liq) else $error("no shutdown");
    property p_ss; $rose(active_q) |-> $past(ss_discharge_q); endproperty
    a_ss: assert property (p_ss) else $error("run without discharge");
    property p_oe; ext_mode_q |-> freq_set_pin_oe_b; endproperty
    a_oe: assert property (p_oe) else $error("pin driven in ext mode");
endmodule // bsfc_checker

// [verification/bsfc_sync_src.sv]
// Square-wave sync source driving the frequency pin
`timescale 1ns/1ps
module bsfc_sync_src (
    input wire logic sys_clk,
    input wire logic run,
    input wire logic [7:0] per,
    input wire logic [7:0] duty,
    output logic drv,
    output logic en
);
    logic [7:0] cnt = 8'h00;
    int d;
    // Duty held inside 20..80 percent
    always_comb d = (duty < 20) ? 20 : (duty > 80) ? 80 : int'(duty);
    always_ff @(posedge sys_clk)
    begin
        en <= run;
        cnt <= (!run || cnt + 8'h01 >= per) ? 8'h00 : cnt + 8'h01;
        drv <= run && (int'(cnt) < int'(per) * d / 100);
    end
endmodule // bsfc_sync_src

// [verification/bsfc_top_test.sv]
// Self-checking bench for switching sync and fault control
`timescale 1ns/1ps
module bsfc_top_test;
    logic sys_clk = 0, rst_b = 0, en_hi = 0, vin_ok = 0, boot_uv = 0, fb_above_ovp = 0;
    logic fb_below_release = 1, cur_trip = 0, comp_clamped = 0, ls_src_lim = 0;
    logic ls_sink_lim = 0, src_run = 0, hs_prev = 0, src_drv, src_en, pin;
    logic trip_off = 0, cur_clamp = 0;
    logic [7:0] src_per = 8'h1e, src_duty = 8'h32;
    logic hs_on_q, ls_on_q, boot_charge_q, ovp_active_q, ss_discharge_q, active_q;
    logic low_iq_q, hiccup_q, ext_mode_q, pll_locked_q, pin_o, pin_oe_b;
    int num_errors = 0, comparisons = 0, cyc = 0, rise_at = 0, gap = 0, i, r0, c0;

    bsfc_top #(.HIC_RESTART_CYC(8)) u_bsfc_top (.sys_clk(sys_clk), .rst_b(rst_b),
        .freq_set_pin_i(pin), .freq_set_pin_o(pin_o), .freq_set_pin_oe_b(pin_oe_b),
        .en_hi(en_hi), .vin_ok(vin_ok), .boot_uv(boot_uv), .fb_above_ovp(fb_above_ovp),
        .fb_below_release(fb_below_release), .cur_trip(cur_trip), .cur_peak_clamp(cur_clamp),
        .comp_clamped(comp_clamped), .ls_src_lim(ls_src_lim), .ls_sink_lim(ls_sink_lim),
        .hs_on_q(hs_on_q), .ls_on_q(ls_on_q), .boot_charge_q(boot_charge_q),
        .ovp_active_q(ovp_active_q), .ss_discharge_q(ss_discharge_q), .active_q(active_q),
        .low_iq_q(low_iq_q), .hiccup_q(hiccup_q), .ext_mode_q(ext_mode_q),
        .pll_locked_q(pll_locked_q));
    bsfc_sync_src u_bsfc_sync_src (.sys_clk(sys_clk), .run(src_run), .per(src_per),
        .duty(src_duty), .drv(src_drv), .en(src_en));
    // Released pin sits at the resistor level
    assign pin = (src_en === 1'b1) ? src_drv : (pin_oe_b === 1'b0) ? pin_o : 1'b0;

    initial forever #25 sys_clk = ~sys_clk;
    // Current sense: normal trip, or clamped peak reference instead
    always @(negedge sys_clk)
    begin
        cur_trip <= hs_on_q && !trip_off;
        cur_clamp <= hs_on_q && trip_off;
    end
    always @(posedge sys_clk)
    begin
        cyc <= cyc + 1;
        hs_prev <= hs_on_q;
        if (hs_on_q && !hs_prev) gap <= cyc - rise_at;
        if (hs_on_q && !hs_prev) rise_at <= cyc;
    end

    function int exp_per(input bit ext, input int p);
        return ext ? p : bsfc_pkg::RT_PER_CYC;
    endfunction
    task tick(input int n);
        repeat (n) @(negedge sys_clk);
    endtask
    task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("mismatch %s expected %0h seen %0h", what, exp, seen);
        end
    endtask
    task final_report;
        $display("comparisons %0d num_errors %0d", comparisons, num_errors);
        if (num_errors == 0 && comparisons > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    initial
    begin
        #(60_000 * bsfc_pkg::SYS_PER_NS);
        num_errors++;
        final_report;
    end

    initial
    begin
        i = $urandom(32'h2d4a_4d52);
        tick(1);
        check("oe_b rst", pin_oe_b, 1);
        check("low_iq rst", low_iq_q, 1);
        tick(4);
        rst_b = 1;
        en_hi = 1;
        vin_ok = 1;
        tick(2);
        check("oe_b rt", pin_oe_b, 0);
        for (i = 0; i < 20 && !ss_discharge_q; i++) tick(1);
        check("discharge", ss_discharge_q, 1);
        tick(bsfc_pkg::SS_DIS_CYC - 1);
        check("early active", active_q, 0);
        tick(1);
        check("active", active_q, 1);
        tick(200);
        check("rt period", gap, exp_per(0, 0));
        $display("test power and rt done");
        src_per = 8'($urandom_range(90, 15));
        src_duty = 8'($urandom_range(80, 20));
        src_run = 1;
        tick(5 * src_per);
        check("ext mode", ext_mode_q, 1);
        check("pin released", pin_oe_b, 1);
        check("locked", pll_locked_q, 1);
        check("ext period", gap, exp_per(1, src_per));
        src_per = 8'h08;
        tick(60);
        check("unlocked", pll_locked_q, 0);
        src_run = 0;
        tick(bsfc_pkg::CLK_LOSS_CYC + 10);
        check("fallback", ext_mode_q, 0);
        check("pin driven", pin_oe_b, 0);
        check("pin low", pin_o, 0);
        tick(100);
        check("rt again", gap, exp_per(0, 0));
        trip_off = 1;
        tick(3);
        r0 = rise_at;
        tick(100);
        check("peak clamp", rise_at != r0, 1);
        trip_off = 0;
        $display("test sync done");
        fb_above_ovp = 1;
        fb_below_release = 0;
        tick(60);
        check("ovp latch", ovp_active_q, 1);
        check("ovp ls", ls_on_q, 1);
        fb_above_ovp = 0;
        r0 = rise_at;
        tick(60);
        check("ovp held", rise_at == r0, 1);
        fb_below_release = 1;
        tick(45);
        check("ovp clear", ovp_active_q, 0);
        check("ovp resume", rise_at != r0, 1);
        ls_src_lim = 1;
        tick(3);
        r0 = rise_at;
        tick(100);
        check("src skip", rise_at == r0, 1);
        check("src ls", ls_on_q, 1);
        ls_src_lim = 0;
        tick(44);
        check("src resume", rise_at != r0, 1);
        $display("test ovp and source done");
        for (i = 0; i < 50 && !(ls_on_q && hs_prev); i++) tick(1);
        ls_sink_lim = 1;
        tick(3);
        check("sink off", {hs_on_q, ls_on_q}, 0);
        ls_sink_lim = 0;
        tick(3);
        check("sink block", ls_on_q, 0);
        boot_uv = 1;
        tick(3);
        check("boot ls", {hs_on_q, ls_on_q}, 1);
        check("boot chg", boot_charge_q, 1);
        boot_uv = 0;
        $display("test sink and boot done");
        comp_clamped = 1;
        c0 = cyc;
        for (i = 0; i < 25_000 && !hiccup_q; i++) tick(1);
        check("hic wait", (cyc - c0) >= 512 * 40 && (cyc - c0) <= 514 * 40, 1);
        comp_clamped = 0;
        c0 = cyc;
        for (i = 0; i < 2000 && !active_q; i++) tick(1);
        check("hic restart", (cyc - c0) >= 8 * 40 && active_q, 1);
        $display("test hiccup done");
        en_hi = 0;
        tick(5);
        check("shutdown", {low_iq_q, active_q}, 2);
        en_hi = 1;
        vin_ok = 0;
        tick(5);
        check("lockout", {low_iq_q, active_q}, 0);
        vin_ok = 1;
        for (i = 0; i < 400; i++)
        begin
            fb_above_ovp = ($urandom % 16) == 0;
            fb_below_release = !fb_above_ovp;
            boot_uv = ($urandom % 32) == 0;
            ls_src_lim = ($urandom % 16) == 0;
            ls_sink_lim = ($urandom % 16) == 0;
            tick(1);
        end
        {fb_above_ovp, boot_uv, ls_src_lim, ls_sink_lim} = 4'h0;
        tick(20);
        check("still active", active_q, 1);
        $display("test random done");
        final_report;
    end
endmodule // bsfc_top_test

bind bsfc_top bsfc_checker u_bsfc_checker (.sys_clk(sys_clk), .rst_b(rst_b), .en_hi(en_hi),
    .vin_ok(vin_ok), .boot_uv(boot_uv), .fb_above_ovp(fb_above_ovp), .ls_src_lim(ls_src_lim),
    .ls_sink_lim(ls_sink_lim), .freq_set_pin_oe_b(freq_set_pin_oe_b), .hs_on_q(hs_on_q),
    .ls_on_q(ls_on_q), .boot_charge_q(boot_charge_q), .ovp_active_q(ovp_active_q),
    .ss_discharge_q(ss_discharge_q), .active_q(active_q), .low_iq_q(low_iq_q),
    .ext_mode_q(ext_mode_q));
